/* File: code_data_memory.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// code, data and stack memory
// ****************************************
module code_data_memory (
   input  wire logic        clk,
   input  wire logic        mem_req_r,
   input  wire logic        mem_we_r,
   input  wire logic        mem_word_r,
   input  wire logic [15:0] mem_addr_r,
   input  wire logic [15:0] mem_wdata_r,
   output logic      [15:0] mem_rdata
);
   logic [7:0] m [65536];
   initial mem_rdata = 16'h0000;
   always @(posedge clk) begin
      if (mem_req_r && mem_we_r && mem_word_r) begin
         m[mem_addr_r] <= mem_wdata_r[15:8];
         m[mem_addr_r + 16'h0001] <= mem_wdata_r[7:0];
      end
      if (mem_req_r && mem_we_r && !mem_word_r)
         m[mem_addr_r] <= mem_wdata_r[7:0];
      // outside a read slot the bus toggles, never holds stale data
      if (mem_req_r && !mem_we_r)
         mem_rdata <= mem_word_r ? {m[mem_addr_r], m[mem_addr_r + 16'h0001]}
            : {8'h00, m[mem_addr_r]};
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule : code_data_memory
`default_nettype wire

/* File: subroutine_ccr_blockmove_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module subroutine_ccr_blockmove_exec
   import subroutine_ccr_blockmove_exec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_w0,
   input  wire logic [15:0] instr_w1,
   input  wire logic [15:0] src_value,
   input  wire logic [15:0] dst_value,
   input  wire logic [7:0]  count_value,
   input  wire logic [15:0] src_ptr_value,
   input  wire logic [15:0] dst_ptr_value,
   input  wire logic        wake,
   input  wire logic [15:0] mem_rdata,
   output logic             busy_r,
   output logic             done_r,
   output logic             sleeping_r,
   output logic [15:0]      pc_r,
   output logic [15:0]      sp_r,
   output logic [7:0]       ccr_r,
   output logic             reg_wr_en_r,
   output logic             reg_wr_word_r,
   output logic [15:0]      reg_wr_data_r,
   output logic [7:0]       byte_counter_r,
   output logic [15:0]      source_pointer_r,
   output logic [15:0]      destination_pointer_r,
   output logic             mem_req_r,
   output logic             mem_we_r,
   output logic             mem_word_r,
   output logic [15:0]      mem_addr_r,
   output logic [15:0]      mem_wdata_r
);

   // ************************************************************
   // decode helpers
   // ************************************************************
   function automatic op_t decode(input logic [15:0] w);
      op_t k;
      k = k_nop;
      case (w[15:8])
         OP_SLEEP:       k = k_sleep;
         OP_STORE_FLAGS: k = k_store_flags;
         OP_LOAD_FL_REG: k = k_load_flags_reg;
         OP_OR_FLAGS:    k = k_or_flags;
         OP_XOR_FLAGS:   k = k_xor_flags;
         OP_AND_FLAGS:   k = k_and_flags;
         OP_LOAD_FL_IMM: k = k_load_flags_imm;
         OP_ADD_WORD:    k = k_add_word;
         OP_ADD_CARRY:   k = k_add_carry;
         OP_ADJ_ADD:     k = k_adj_add;
         OP_SUB_WORD:    k = k_sub_word;
         OP_SUB_BORROW:  k = k_sub_borrow;
         OP_ADJ_SUB:     k = k_adj_sub;
         OP_UDIVIDE:     k = k_udivide;
         OP_RET_SUB:     k = k_ret_sub;
         OP_RET_EXC:     k = k_ret_exc;
         OP_CALL_REG:    k = k_call_reg;
         OP_CALL_ABS:    k = k_call_abs;
         OP_CALL_IND:    k = k_call_ind;
         OP_BLOCK_MOVE:  k = w[7] ? k_nop : k_block_move;
         default:        k = k_nop;
      endcase
      return k;
   endfunction : decode

   function automatic logic [10:0] exec_states(input op_t k,
                                               input logic [7:0] n);
      logic [10:0] s;
      s = ST_SHORT;
      case (k)
         k_call_reg:   s = ST_CALL_REG;
         k_call_abs:   s = ST_CALL_LONG;
         k_call_ind:   s = ST_CALL_LONG;
         k_ret_sub:    s = ST_RET_SUB;
         k_ret_exc:    s = ST_RET_EXC;
         k_block_move: s = 11'(ST_MOVE_PER * {3'h0, n} + ST_MOVE_BASE);
         default:      s = ST_SHORT;
      endcase
      return s;
   endfunction : exec_states

   function automatic logic [15:0] instr_len(input op_t k);
      return (k == k_call_abs || k == k_block_move) ? LEN_LONG : LEN_SHORT;
   endfunction : instr_len

   exec_state_t state_r;
   op_t         op_r;
   logic [10:0] cnt_r;
   logic [10:0] step_r;
   logic [15:0] w0_r;
   logic [15:0] w1_r;
   logic [15:0] src_r;
   logic [15:0] dst_r;
   logic [15:0] fetched_r;
   logic        wake_s1_r;
   logic        wake_s2_r;
   logic        accept;
   logic        last;
   logic        moving;
   logic [15:0] ret_pc;
   logic [7:0]  ccr_nxt;
   logic        wr_en_nxt;
   logic        wr_word_nxt;
   logic [15:0] wr_data_nxt;
   logic [16:0] sum17;
   logic [12:0] sum13;
   logic [8:0]  sum9;
   logic [4:0]  sum5;
   logic        lo_adj;
   logic        hi_adj;
   logic [7:0]  adj;
   logic [15:0] quo;
   logic [15:0] rem;

   assign accept = (state_r == s_idle) && instr_valid && !sleeping_r;
   assign last   = (state_r == s_exec) && (cnt_r == 11'h000);
   assign moving = (op_r == k_block_move) && (state_r == s_exec)
                   && (byte_counter_r != 8'h00);
   assign ret_pc = pc_r + instr_len(op_r);

   // ************************************************************
   // flag and result arithmetic
   // ************************************************************
   always_comb begin
      ccr_nxt     = ccr_r;
      wr_en_nxt   = 1'b0;
      wr_word_nxt = 1'b0;
      wr_data_nxt = 16'h0000;
      sum17       = 17'h00000;
      sum13       = 13'h0000;
      sum9        = 9'h000;
      sum5        = 5'h00;
      lo_adj      = 1'b0;
      hi_adj      = 1'b0;
      adj         = 8'h00;
      quo         = 16'h0000;
      rem         = 16'h0000;
      case (op_r)
         k_load_flags_imm: ccr_nxt = w0_r[7:0];
         k_load_flags_reg: ccr_nxt = src_r[7:0];
         k_and_flags:      ccr_nxt = ccr_r & w0_r[7:0];
         k_or_flags:       ccr_nxt = ccr_r | w0_r[7:0];
         k_xor_flags:      ccr_nxt = ccr_r ^ w0_r[7:0];
         k_store_flags: begin
            wr_en_nxt   = 1'b1;
            wr_data_nxt = {8'h00, ccr_r};
         end
         k_add_word, k_sub_word: begin
            if (op_r == k_add_word) begin
               sum17 = {1'b0, dst_r} + {1'b0, src_r};
               sum13 = {1'b0, dst_r[11:0]} + {1'b0, src_r[11:0]};
               ccr_nxt[FLAG_V] = (dst_r[15] == src_r[15])
                                 && (sum17[15] != dst_r[15]);
            end else begin
               sum17 = {1'b0, dst_r} - {1'b0, src_r};
               sum13 = {1'b0, dst_r[11:0]} - {1'b0, src_r[11:0]};
               ccr_nxt[FLAG_V] = (dst_r[15] != src_r[15])
                                 && (sum17[15] != dst_r[15]);
            end
            ccr_nxt[FLAG_H] = sum13[12];
            ccr_nxt[FLAG_N] = sum17[15];
            ccr_nxt[FLAG_Z] = (sum17[15:0] == 16'h0000);
            ccr_nxt[FLAG_C] = sum17[16];
            wr_en_nxt       = 1'b1;
            wr_word_nxt     = 1'b1;
            wr_data_nxt     = sum17[15:0];
         end
         k_add_carry, k_sub_borrow: begin
            if (op_r == k_add_carry) begin
               sum9 = {1'b0, dst_r[7:0]} + {1'b0, src_r[7:0]}
                      + {8'h00, ccr_r[FLAG_C]};
               sum5 = {1'b0, dst_r[3:0]} + {1'b0, src_r[3:0]}
                      + {4'h0, ccr_r[FLAG_C]};
               ccr_nxt[FLAG_V] = (dst_r[7] == src_r[7])
                                 && (sum9[7] != dst_r[7]);
            end else begin
               sum9 = {1'b0, dst_r[7:0]} - {1'b0, src_r[7:0]}
                      - {8'h00, ccr_r[FLAG_C]};
               sum5 = {1'b0, dst_r[3:0]} - {1'b0, src_r[3:0]}
                      - {4'h0, ccr_r[FLAG_C]};
               ccr_nxt[FLAG_V] = (dst_r[7] != src_r[7])
                                 && (sum9[7] != dst_r[7]);
            end
            ccr_nxt[FLAG_H] = sum5[4];
            ccr_nxt[FLAG_N] = sum9[7];
            ccr_nxt[FLAG_Z] = (sum9[7:0] == 8'h00) && ccr_r[FLAG_Z];
            ccr_nxt[FLAG_C] = sum9[8];
            wr_en_nxt       = 1'b1;
            wr_data_nxt     = {8'h00, sum9[7:0]};
         end
         k_adj_add, k_adj_sub: begin
            // correction from the flags left by the previous op, and for adjust-after-add also from the digit values
            if (op_r == k_adj_add) begin
               lo_adj = ccr_r[FLAG_H] || (dst_r[3:0] > 4'h9);
               hi_adj = ccr_r[FLAG_C] || (dst_r[7:0] > 8'h99);
            end else begin
               lo_adj = ccr_r[FLAG_H];
               hi_adj = ccr_r[FLAG_C];
            end
            adj  = {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
            sum9 = (op_r == k_adj_add) ? {1'b0, dst_r[7:0]} + {1'b0, adj}
                                       : {1'b0, dst_r[7:0]} - {1'b0, adj};
            ccr_nxt[FLAG_N] = sum9[7];
            ccr_nxt[FLAG_Z] = (sum9[7:0] == 8'h00);
            ccr_nxt[FLAG_C] = hi_adj || ccr_r[FLAG_C];
            wr_en_nxt       = 1'b1;
            wr_data_nxt     = {8'h00, sum9[7:0]};
         end
         k_udivide: begin
            ccr_nxt[FLAG_N] = src_r[7];
            ccr_nxt[FLAG_Z] = (src_r[7:0] == 8'h00);
            // a zero divisor leaves the destination alone
            if (src_r[7:0] != 8'h00) begin
               quo         = dst_r / {8'h00, src_r[7:0]};
               rem         = dst_r % {8'h00, src_r[7:0]};
               wr_en_nxt   = 1'b1;
               wr_word_nxt = 1'b1;
               wr_data_nxt = {rem[7:0], quo[7:0]};
            end
         end
         default: ccr_nxt = ccr_r;
      endcase
   end

   // ************************************************************
   // sequencing
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= s_idle;
         cnt_r   <= 11'h000;
         step_r  <= 11'h000;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         done_r <= last;
         if (accept) begin
            state_r <= s_exec;
            cnt_r   <= exec_states(decode(instr_w0), count_value)
                       - 11'h001;
            step_r  <= 11'h000;
            busy_r  <= 1'b1;
         end else if (state_r == s_exec) begin
            step_r <= step_r + 11'h001;
            if (last) begin
               state_r <= s_idle;
               busy_r  <= 1'b0;
            end else begin
               cnt_r <= cnt_r - 11'h001;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r  <= k_nop;
         w0_r  <= 16'h0000;
         w1_r  <= 16'h0000;
         src_r <= 16'h0000;
         dst_r <= 16'h0000;
      end else if (accept) begin
         op_r  <= decode(instr_w0);
         w0_r  <= instr_w0;
         w1_r  <= instr_w1;
         src_r <= src_value;
         dst_r <= dst_value;
      end
   end

   // wake is asynchronous to the core clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_s1_r  <= 1'b0;
         wake_s2_r  <= 1'b0;
         sleeping_r <= 1'b0;
      end else begin
         wake_s1_r <= wake;
         wake_s2_r <= wake_s1_r;
         if (last && op_r == k_sleep) begin
            sleeping_r <= 1'b1;
         end else if (wake_s2_r) begin
            sleeping_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // memory port and stack
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_word_r  <= 1'b0;
         mem_addr_r  <= 16'h0000;
         mem_wdata_r <= 16'h0000;
      end else begin
         mem_req_r  <= 1'b0;
         mem_we_r   <= 1'b0;
         mem_word_r <= 1'b0;
         if (state_r == s_exec) begin
            if ((op_r == k_call_reg || op_r == k_call_abs
                 || op_r == k_call_ind) && step_r == 11'h000) begin
               mem_req_r   <= 1'b1;
               mem_we_r    <= 1'b1;
               mem_word_r  <= 1'b1;
               mem_addr_r  <= sp_r - SP_STEP;
               mem_wdata_r <= ret_pc;
            end else if (op_r == k_call_ind && step_r == 11'h001) begin
               mem_req_r  <= 1'b1;
               mem_word_r <= 1'b1;
               mem_addr_r <= {PAGE_ZERO, w0_r[7:0]};
            end else if ((op_r == k_ret_sub || op_r == k_ret_exc)
                         && step_r == 11'h000) begin
               mem_req_r  <= 1'b1;
               mem_word_r <= 1'b1;
               mem_addr_r <= sp_r;
            end else if (op_r == k_ret_exc && step_r == 11'h002) begin
               mem_req_r  <= 1'b1;
               mem_word_r <= 1'b1;
               mem_addr_r <= sp_r + SP_STEP;
            end else if (moving && step_r[1:0] == 2'h0) begin
               mem_req_r  <= 1'b1;
               mem_addr_r <= source_pointer_r;
            end else if (moving && step_r[1:0] == 2'h2) begin
               mem_req_r   <= 1'b1;
               mem_we_r    <= 1'b1;
               mem_addr_r  <= destination_pointer_r;
               mem_wdata_r <= {8'h00, mem_rdata[7:0]};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= SP_RST;
      end else if (state_r == s_exec) begin
         if ((op_r == k_call_reg || op_r == k_call_abs
              || op_r == k_call_ind) && step_r == 11'h000) begin
            sp_r <= sp_r - SP_STEP;
         end else if (op_r == k_ret_exc && step_r == 11'h002) begin
            sp_r <= sp_r + SP_STEP;
         end else if (last && (op_r == k_ret_sub || op_r == k_ret_exc)) begin
            sp_r <= sp_r + SP_STEP;
         end
      end
   end

   // ************************************************************
   // program counter and flags
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetched_r <= 16'h0000;
         pc_r      <= PC_RST;
      end else begin
         if ((op_r == k_call_ind && step_r == 11'h003)
             || (op_r == k_ret_sub && step_r == 11'h002)
             || (op_r == k_ret_exc && step_r == 11'h004)) begin
            fetched_r <= mem_rdata;
         end
         if (last) begin
            case (op_r)
               k_call_reg: pc_r <= src_r;
               k_call_abs: pc_r <= w1_r;
               k_call_ind, k_ret_sub, k_ret_exc: pc_r <= fetched_r;
               default:    pc_r <= ret_pc;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ccr_r <= FLAGS_RST;
      end else if (op_r == k_ret_exc && step_r == 11'h002
                   && state_r == s_exec) begin
         ccr_r <= mem_rdata[7:0];
      end else if (last) begin
         ccr_r <= ccr_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_wr_en_r   <= 1'b0;
         reg_wr_word_r <= 1'b0;
         reg_wr_data_r <= 16'h0000;
      end else begin
         reg_wr_en_r <= last && wr_en_nxt;
         if (last) begin
            reg_wr_word_r <= wr_word_nxt;
            reg_wr_data_r <= wr_data_nxt;
         end
      end
   end

   // ************************************************************
   // block move pointers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_counter_r        <= 8'h00;
         source_pointer_r      <= 16'h0000;
         destination_pointer_r <= 16'h0000;
      end else if (accept && decode(instr_w0) == k_block_move) begin
         byte_counter_r        <= count_value;
         source_pointer_r      <= src_ptr_value;
         destination_pointer_r <= dst_ptr_value;
      end else if (moving && step_r[1:0] == 2'h2) begin
         byte_counter_r        <= byte_counter_r - 8'h01;
         source_pointer_r      <= source_pointer_r + 16'h0001;
         destination_pointer_r <= destination_pointer_r + 16'h0001;
      end
   end

endmodule : subroutine_ccr_blockmove_exec
`default_nettype wire

/* File: subroutine_ccr_blockmove_exec_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checks
// ****************************************
module subroutine_ccr_blockmove_exec_checker
   import subroutine_ccr_blockmove_exec_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_w0,
   input wire logic [15:0] instr_w1,
   input wire logic [15:0] src_value,
   input wire logic [7:0]  count_value,
   input wire logic        busy_r,
   input wire logic        done_r,
   input wire logic        sleeping_r,
   input wire logic [15:0] pc_r,
   input wire logic [15:0] sp_r,
   input wire logic [7:0]  ccr_r,
   input wire logic        mem_req_r,
   input wire logic        mem_we_r,
   input wire logic [15:0] mem_addr_r,
   input wire logic [15:0] mem_wdata_r
);
   logic       tk;
   logic [7:0] op;
   assign tk = instr_valid && !busy_r && !sleeping_r;
   assign op = instr_w0[15:8];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_two; busy_r[*2] ##1 (done_r && !busy_r); endsequence
   sequence s_six; busy_r[*6] ##1 (done_r && !busy_r); endsequence
   sequence s_eight; busy_r[*8] ##1 (done_r && !busy_r); endsequence
   a_call_push: assert property (tk && op == OP_CALL_REG |=>
      ##1 mem_req_r && mem_we_r && mem_addr_r == $past(sp_r) - 16'h0002
      && mem_wdata_r == $past(pc_r) + 16'h0002) else $error("bad push");
   a_call_reg_pc: assert property (tk && op == OP_CALL_REG |=>
      s_six ##0 pc_r == $past(src_value, 7)) else $error("call reg");
   a_call_abs_pc: assert property (tk && op == OP_CALL_ABS |=>
      s_eight ##0 (pc_r == $past(instr_w1, 9)
      && sp_r == $past(sp_r, 9) - 16'h0002)) else $error("call abs");
   a_call_ind_time: assert property (tk && op == OP_CALL_IND |=>
      s_eight) else $error("call indirect");
   a_ret_sub_sp: assert property (tk && op == OP_RET_SUB |=>
      s_eight ##0 (sp_r == $past(sp_r, 9) + 16'h0002
      && ccr_r == $past(ccr_r, 9))) else $error("return");
   a_exc_ret_sp: assert property (tk && op == OP_RET_EXC |=>
      busy_r[*5] ##1 busy_r[*5] ##1 (done_r
      && sp_r == $past(sp_r, 11) + 16'h0004)) else $error("exc return");
   a_short_ops: assert property (tk && op <= 8'h07 |=> s_two)
      else $error("short op time");
   a_sleep_flags: assert property (tk && op == OP_SLEEP |=>
      s_two ##0 (sleeping_r && ccr_r == $past(ccr_r, 3)))
      else $error("sleep");
   a_move_empty: assert property (tk && op == OP_BLOCK_MOVE
      && !instr_w0[7] && count_value == 8'h00 |=>
      busy_r[*8] ##1 busy_r ##1 done_r) else $error("empty move");
   a_move_split: assert property (tk && op == OP_BLOCK_MOVE
      && instr_w0[7] |=> s_two ##0 pc_r == $past(pc_r, 3) + 16'h0002)
      else $error("split code");
endmodule : subroutine_ccr_blockmove_exec_checker
bind subroutine_ccr_blockmove_exec subroutine_ccr_blockmove_exec_checker
   u_chk (.*);
`default_nettype wire

/* File: subroutine_ccr_blockmove_exec_pkg.sv */
// Function
// - call via register: sp minus 2, push return pc, pc from register, 6 states
// - call absolute: push return pc, pc from 16-bit address, 4 bytes, 8 states
// - call indirect: push return pc, pc from word at 8-bit address, 8 states
// - return: pc from stack top word, then sp plus 2, 8 states
// - exception return: pop flags, sp plus 2, pop pc, sp plus 2, 10 states
// - sleep enters low-power mode, flags untouched, 2 bytes, 2 states
// - block move copies bytes, bumps pointers, counts down until counter zero
// - block move is 4 bytes long and takes 4n + 9 states
// - word arithmetic half-carry is carry or borrow out of bit 11
// - carry-chained add or subtract: zero result keeps zero flag, else clears
// - decimal adjust sets carry on adjust carry, else keeps old carry
// - divide sets negative flag when divisor is negative, else clears it
// - divide sets zero flag when divisor is zero, else clears it
// - primary opcode is bits 15 to 8 of the first word
// - shared first-byte codes split on bit 7 of the first word
package subroutine_ccr_blockmove_exec_pkg;

   localparam logic [7:0] OP_SLEEP       = 8'h01;
   localparam logic [7:0] OP_STORE_FLAGS = 8'h02;
   localparam logic [7:0] OP_LOAD_FL_REG = 8'h03;
   localparam logic [7:0] OP_OR_FLAGS    = 8'h04;
   localparam logic [7:0] OP_XOR_FLAGS   = 8'h05;
   localparam logic [7:0] OP_AND_FLAGS   = 8'h06;
   localparam logic [7:0] OP_LOAD_FL_IMM = 8'h07;
   localparam logic [7:0] OP_ADD_WORD    = 8'h09;
   localparam logic [7:0] OP_ADD_CARRY   = 8'h0e;
   localparam logic [7:0] OP_ADJ_ADD     = 8'h0f;
   localparam logic [7:0] OP_SUB_WORD    = 8'h19;
   localparam logic [7:0] OP_SUB_BORROW  = 8'h1e;
   localparam logic [7:0] OP_ADJ_SUB     = 8'h1f;
   localparam logic [7:0] OP_UDIVIDE     = 8'h51;
   localparam logic [7:0] OP_RET_SUB     = 8'h54;
   localparam logic [7:0] OP_RET_EXC     = 8'h56;
   localparam logic [7:0] OP_CALL_REG    = 8'h5d;
   localparam logic [7:0] OP_CALL_ABS    = 8'h5e;
   localparam logic [7:0] OP_CALL_IND    = 8'h5f;
   localparam logic [7:0] OP_BLOCK_MOVE  = 8'h7b;

   localparam logic [10:0] ST_CALL_REG   = 11'h006;
   localparam logic [10:0] ST_CALL_LONG  = 11'h008;
   localparam logic [10:0] ST_RET_SUB    = 11'h008;
   localparam logic [10:0] ST_RET_EXC    = 11'h00a;
   localparam logic [10:0] ST_SHORT      = 11'h002;
   localparam logic [10:0] ST_MOVE_BASE  = 11'h009;
   localparam logic [10:0] ST_MOVE_PER   = 11'h004;

   localparam logic [15:0] LEN_SHORT     = 16'h0002;
   localparam logic [15:0] LEN_LONG      = 16'h0004;
   localparam logic [15:0] SP_STEP       = 16'h0002;
   localparam logic [15:0] PC_RST        = 16'h0000;
   localparam logic [15:0] SP_RST        = 16'hff00;
   localparam logic [7:0]  FLAGS_RST     = 8'h80;
   localparam logic [7:0]  PAGE_ZERO     = 8'h00;

   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam int FLAG_H = 5;

   typedef enum logic [1:0] {
      s_idle = 2'b01,
      s_exec = 2'b10
   } exec_state_t;

   typedef enum logic [4:0] {
      k_nop, k_sleep, k_store_flags, k_load_flags_imm, k_load_flags_reg,
      k_and_flags, k_or_flags, k_xor_flags, k_add_word, k_sub_word,
      k_add_carry, k_sub_borrow, k_adj_add, k_adj_sub, k_udivide,
      k_ret_sub, k_ret_exc, k_call_reg, k_call_abs, k_call_ind,
      k_block_move
   } op_t;

endpackage : subroutine_ccr_blockmove_exec_pkg

/* File: test_subroutine_ccr_blockmove_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module test_subroutine_ccr_blockmove_exec;
   import subroutine_ccr_blockmove_exec_pkg::*;
   logic clk, rst_n, instr_valid, wake, busy_r, done_r, sleeping_r;
   logic reg_wr_en_r, reg_wr_word_r, mem_req_r, mem_we_r, mem_word_r;
   logic [15:0] instr_w0, instr_w1, src_value, dst_value, src_ptr_value;
   logic [15:0] dst_ptr_value, mem_rdata, pc_r, sp_r, reg_wr_data_r;
   logic [15:0] source_pointer_r, destination_pointer_r, mem_addr_r;
   logic [15:0] mem_wdata_r;
   logic [7:0]  count_value, ccr_r, byte_counter_r;
   logic [15:0] fl;
   int          n_fail, n_tests, cyc_cnt, i;
   logic [15:0] tw [5];
   logic [15:0] tf [5];
   assign fl = {8'h00, ccr_r};
   subroutine_ccr_blockmove_exec u_subroutine_ccr_blockmove_exec (.*);
   code_data_memory u_mem (.*);
   always #20 clk = ~clk;
   task automatic chk(input string nm, input logic [15:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   function automatic logic [15:0] mw(input logic [15:0] a);
      return {u_mem.m[a], u_mem.m[a + 16'h0001]};
   endfunction : mw
   // waits on done with a bound; the cycle count is the check
   task automatic run(input logic [15:0] w0, sv, dv,
                      input logic [7:0] n, input int st);
      int k;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_w0 <= w0;
      src_value <= sv;
      dst_value <= dv;
      count_value <= n;
      @(posedge clk);
      instr_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (done_r !== 1'b1 && k < 300);
      chk("states", 16'(k), 16'(st + 1));
      $display("test %h done", w0);
   endtask : run
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 2000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      {clk, rst_n, instr_valid, wake, count_value} = '0;
      {instr_w0, src_value, dst_value} = '0;
      instr_w1 = 16'h1234;
      src_ptr_value = 16'h0100;
      dst_ptr_value = 16'h0200;
      tw = '{16'h072b, 16'h060f, 16'h0440, 16'h05ff, 16'h0300};
      tf = '{16'h002b, 16'h000b, 16'h004b, 16'h00b4, 16'h00c5};
      {u_mem.m[16'h0040], u_mem.m[16'h0041]} = 16'h5678;
      {u_mem.m[16'h0100], u_mem.m[16'h0101]} = 16'h1122;
      u_mem.m[16'h0102] = 8'h33;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      run(16'h0000, 16'h0000, 16'h0000, 8'h00, 2);
      chk("pc", pc_r, 16'h0002);
      chk("fl", fl, 16'h0080);
      for (i = 0; i < 5; i++) begin
         run(tw[i], 16'h00c5, 16'h0000, 8'h00, 2);
         chk("fl", fl, tf[i]);
      end
      run(16'h0200, 16'h0000, 16'h0000, 8'h00, 2);
      chk("stored", {reg_wr_en_r, 7'h00, reg_wr_data_r[7:0]}, 16'h80c5);
      run(16'h5d00, 16'h0400, 16'h0000, 8'h00, 6);
      chk("pc", pc_r, 16'h0400);
      chk("sp", sp_r, 16'hfefe);
      chk("push", mw(16'hfefe), 16'h0010);
      chk("fl", fl, 16'h00c5);
      run(16'h5e00, 16'h0000, 16'h0000, 8'h00, 8);
      chk("pc", pc_r, 16'h1234);
      chk("push", mw(16'hfefc), 16'h0404);
      run(16'h5f40, 16'h0000, 16'h0000, 8'h00, 8);
      chk("pc", pc_r, 16'h5678);
      chk("push", mw(16'hfefa), 16'h1236);
      run(16'h5400, 16'h0000, 16'h0000, 8'h00, 8);
      chk("pc", pc_r, 16'h1236);
      chk("sp", sp_r, 16'hfefc);
      {u_mem.m[16'hfefc], u_mem.m[16'hfefd]} = 16'h002a;
      {u_mem.m[16'hfefe], u_mem.m[16'hfeff]} = 16'h4321;
      run(16'h5600, 16'h0000, 16'h0000, 8'h00, 10);
      chk("fl", fl, 16'h002a);
      chk("pc", pc_r, 16'h4321);
      chk("sp", sp_r, 16'hff00);
      run(16'h7b00, 16'h0000, 16'h0000, 8'h03, 21);
      chk("copy", mw(16'h0200), 16'h1122);
      chk("copy", 16'(u_mem.m[16'h0202]), 16'h0033);
      chk("src", source_pointer_r, 16'h0103);
      chk("dst", destination_pointer_r, 16'h0203);
      chk("cnt", 16'(byte_counter_r), 16'h0000);
      chk("fl", fl, 16'h002a);
      run(16'h7b00, 16'h0000, 16'h0000, 8'h00, 9);
      run(16'h7b80, 16'h0000, 16'h0000, 8'h05, 2);
      chk("pc", pc_r, 16'h432b);
      run(16'h0900, 16'h0800, 16'h0800, 8'h00, 2);
      chk("sum", reg_wr_data_r, 16'h1000);
      chk("half", {7'h0, ccr_r[5], 7'h0, reg_wr_word_r}, 16'h0101);
      run(16'h1900, 16'h0001, 16'h0001, 8'h00, 2);
      chk("half", 16'(ccr_r[5]), 16'h0000);
      run(16'h0704, 16'h0000, 16'h0000, 8'h00, 2);
      run(16'h0e00, 16'h0000, 16'h0000, 8'h00, 2);
      chk("zero", 16'(ccr_r[2]), 16'h0001);
      run(16'h1e00, 16'h0001, 16'h0000, 8'h00, 2);
      chk("zero", 16'(ccr_r[2]), 16'h0000);
      run(16'h0f00, 16'h0000, 16'h009a, 8'h00, 2);
      chk("carry", 16'(ccr_r[0]), 16'h0001);
      run(16'h1f00, 16'h0000, 16'h0012, 8'h00, 2);
      chk("carry", 16'(ccr_r[0]), 16'h0001);
      run(16'h5100, 16'h0080, 16'h0100, 8'h00, 2);
      chk("neg", {7'h00, ccr_r[3], 7'h00, ccr_r[2]}, 16'h0100);
      run(16'h5100, 16'h0000, 16'h0100, 8'h00, 2);
      chk("neg", {7'h00, ccr_r[3], 7'h00, ccr_r[2]}, 16'h0001);
      run(16'h0100, 16'h0000, 16'h0000, 8'h00, 2);
      chk("sleep", 16'(sleeping_r), 16'h0001);
      @(posedge clk);
      wake <= 1'b1;
      repeat (5) @(negedge clk);
      chk("sleep", 16'(sleeping_r), 16'h0000);
      complete_run();
   end
endmodule : test_subroutine_ccr_blockmove_exec
`default_nettype wire
